// ---- common/dwt_defs.svh ----
// Register map, field positions and reset values of the wait-state block.
// Assumes a 12-bit APB byte address; each register takes one aligned word.
`ifndef DWT_DEFS_SVH
`define DWT_DEFS_SVH

`define DWT_IDX_CTRL 10'h001
`define DWT_IDX_STAT 10'h002
`define DWT_ADDR_CTRL {`DWT_IDX_CTRL, 2'b00}
`define DWT_ADDR_STAT {`DWT_IDX_STAT, 2'b00}
`define DWT_CTRL_RST 8'hC0
`define DWT_IO_WS_HI 7
`define DWT_IO_WS_LO 6
`define DWT_WS16_HI 5
`define DWT_WS16_LO 4
`define DWT_WS8_HI 3
`define DWT_WS8_LO 2
`define DWT_MEMR_NODLY 1
`define DWT_CLK_FAST 0
`define DWT_PORT_RTC 8'h70

`endif

// ---- common/dwt_pkg.sv ----
// Types shared by the wait-state block.
// Assumes nothing of its surroundings.
`default_nettype none
package dwt_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_SYNC, ST_CMD} dwt_state_t;
endpackage
`default_nettype wire

// ---- rtl/dwt_dma_seq.sv ----
// DMA command strobe sequencer, stepping on the transfer-clock enable.
// Assumes start, hold and tick come from logic on pclk.
`include "dwt_defs.svh"
`default_nettype none
module dwt_dma_seq (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tick,
  input wire logic start,
  input wire logic wide,
  input wire logic mem_to_io,
  input wire logic memr_nodelay,
  input wire logic [1:0] ws16,
  input wire logic [1:0] ws8,
  input wire logic hold,
  output logic ior_n,
  output logic iow_n,
  output logic memr_n,
  output logic memw_n,
  output logic busy,
  output logic done,
  output logic stretch
);
  dwt_pkg::dwt_state_t st_q, st_d;
  logic [2:0] cnt_q, cnt_d, lim_q, lim_d;
  logic m2io_q, m2io_d, nodly_q, nodly_d;
  logic ior_n_q, ior_n_d, iow_n_q, iow_n_d, memr_n_q, memr_n_d, memw_n_q, memw_n_d;
  logic done_q, done_d, stretch_q, stretch_d;
  logic busy_q, busy_d;

  always_comb
  begin
    st_d = st_q;
    cnt_d = cnt_q;
    lim_d = lim_q;
    m2io_d = m2io_q;
    nodly_d = nodly_q;
    ior_n_d = ior_n_q;
    iow_n_d = iow_n_q;
    memr_n_d = memr_n_q;
    memw_n_d = memw_n_q;
    done_d = 1'b0;
    stretch_d = 1'b0;
    case (st_q)
      dwt_pkg::ST_IDLE:
      begin
        if (start)
        begin
          lim_d = {1'b0, wide ? ws16 : ws8} + 3'h1;
          m2io_d = mem_to_io;
          nodly_d = memr_nodelay;
          st_d = dwt_pkg::ST_SYNC;
        end
      end
      dwt_pkg::ST_SYNC:
      begin
        if (tick)
        begin
          cnt_d = 3'h0;
          st_d = dwt_pkg::ST_CMD;
          iow_n_d = ~m2io_q;
          ior_n_d = m2io_q;
          memw_n_d = m2io_q;
          // undelayed read strobe follows the I/O strobe
          memr_n_d = ~(m2io_q & nodly_q);
        end
      end
      dwt_pkg::ST_CMD:
      begin
        stretch_d = hold;
        if (tick)
        begin
          // delayed read strobe comes one transfer clock later
          if (m2io_q)
            memr_n_d = 1'b0;
          // low time is the wait count plus one transfer clock
          if (cnt_q != lim_q)
            cnt_d = cnt_q + 3'h1;
          // local timing may hold the command longer
          else if (!hold)
          begin
            ior_n_d = 1'b1;
            iow_n_d = 1'b1;
            memr_n_d = 1'b1;
            memw_n_d = 1'b1;
            done_d = 1'b1;
            st_d = dwt_pkg::ST_IDLE;
          end
        end
      end
      default:
        st_d = dwt_pkg::ST_IDLE;
    endcase
    // Registered so the busy output comes straight from a flop
    busy_d = (st_d != dwt_pkg::ST_IDLE);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q <= dwt_pkg::ST_IDLE;
      cnt_q <= 3'h0;
      lim_q <= 3'h1;
      m2io_q <= 1'b0;
      nodly_q <= 1'b0;
      ior_n_q <= 1'b1;
      iow_n_q <= 1'b1;
      memr_n_q <= 1'b1;
      memw_n_q <= 1'b1;
      done_q <= 1'b0;
      stretch_q <= 1'b0;
      busy_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      lim_q <= lim_d;
      m2io_q <= m2io_d;
      nodly_q <= nodly_d;
      ior_n_q <= ior_n_d;
      iow_n_q <= iow_n_d;
      memr_n_q <= memr_n_d;
      memw_n_q <= memw_n_d;
      done_q <= done_d;
      stretch_q <= stretch_d;
      busy_q <= busy_d;
    end
  end

  assign ior_n = ior_n_q;
  assign iow_n = iow_n_q;
  assign memr_n = memr_n_q;
  assign memw_n = memw_n_q;
  assign busy = busy_q;
  assign done = done_q;
  assign stretch = stretch_q;

  property p_memr_delay;
    @(posedge pclk) disable iff (!presetn)
    $fell(iow_n_q) && !nodly_q |-> memr_n_q ##[1:2] !memr_n_q;
  endproperty
  a_memr_delay: assert property (p_memr_delay) else $error("read strobe not delayed one transfer clock");

  property p_memr_same;
    @(posedge pclk) disable iff (!presetn)
    $fell(iow_n_q) && nodly_q |-> !memr_n_q;
  endproperty
  a_memr_same: assert property (p_memr_same) else $error("read strobe not aligned with I/O strobe");

  property p_min_low;
    @(posedge pclk) disable iff (!presetn)
    $fell(iow_n_q) || $fell(ior_n_q) |-> (!iow_n_q || !ior_n_q) [*2];
  endproperty
  a_min_low: assert property (p_min_low) else $error("command low shorter than two cycles");

  property p_ws_count;
    @(posedge pclk) disable iff (!presetn)
    $rose(memw_n_q) || $rose(iow_n_q) |-> $past(cnt_q) == $past(lim_q);
  endproperty
  a_ws_count: assert property (p_ws_count) else $error("command released before wait count");

  property p_hold;
    @(posedge pclk) disable iff (!presetn)
    st_q == dwt_pkg::ST_CMD && cnt_q == lim_q && hold |=> (st_q == dwt_pkg::ST_CMD) && stretch_q;
  endproperty
  a_hold: assert property (p_hold) else $error("local hold did not stretch command");
endmodule // dwt_dma_seq
`default_nettype wire

// ---- rtl/dwt_top.sv ----
// Wait-state timing for expansion-bus I/O and DMA cycles, with APB registers.
// Assumes io/dma request inputs come from pclk logic; iochrdy_in is a pin.
// Functional notes
// - Peripheral-core I/O gets one to four bus-clock waits from bits 7:6 via IOCHRDY.
// - Port 70h is outside the peripheral core and gets no programmed waits.
// - 16-bit DMA inserts one to four transfer-clock waits from bits 5:4.
// - 8-bit DMA inserts one to four transfer-clock waits from bits 3:2.
// - DMA waits lengthen the write command; one wait gives two transfer clocks low.
// - Local timing may stretch DMA cycles beyond the count, pulling IOCHRDY.
// - Bit 1 clear delays MEMR one transfer clock after IOW; set aligns them.
// - Control register resets to C0h; 00h is the usual setting.
//
// The implementer's own choice: register access over APB.
`include "dwt_defs.svh"
`default_nettype none
module dwt_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic io_cycle,
  input wire logic [7:0] io_port,
  input wire logic dma_start,
  input wire logic dma_wide,
  input wire logic dma_mem_to_io,
  input wire logic local_hold,
  input wire logic iochrdy_in,
  output logic iochrdy_out,
  output logic iochrdy_oe,
  output logic ior_n,
  output logic iow_n,
  output logic memr_n,
  output logic memw_n,
  output logic dma_busy,
  output logic dma_done
);
  function automatic logic core_port(input logic [7:0] p);
    core_port = (p <= 8'h0F) || (p >= 8'h20 && p <= 8'h23) || (p >= 8'h40 && p <= 8'h43) ||
                (p == 8'h71) || (p >= 8'h80 && p <= 8'h8F) || (p == 8'hA0) || (p == 8'hA1) ||
                (p >= 8'hC0 && p <= 8'hDF);
  endfunction

  logic [7:0] ctrl_q, ctrl_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d, pslverr_q, pslverr_d;
  logic rdy_s1_q, rdy_s2_q;
  logic io_cycle_q, io_start;
  logic [2:0] io_cnt_q, io_cnt_d;
  logic tick_q, tick_d;
  logic oe_q, oe_d;
  logic seq_stretch, seq_busy;
  logic wr_ctrl, acc;

  // APB slave: one wait cycle, registered answer
  assign acc = psel & penable & ~pready_q;
  assign wr_ctrl = psel & penable & pready_q & pwrite & (paddr == `DWT_ADDR_CTRL);

  always_comb
  begin
    ctrl_d = ctrl_q;
    pready_d = acc;
    prdata_d = 32'h0000_0000;
    pslverr_d = 1'b0;
    if (wr_ctrl)
      ctrl_d = pwdata[7:0];
    if (acc)
    begin
      if (paddr == `DWT_ADDR_CTRL)
        prdata_d = {24'h00_0000, ctrl_q};
      else if (paddr == `DWT_ADDR_STAT)
        prdata_d = {26'h000_0000, rdy_s2_q, seq_busy, oe_q, io_cnt_q};
      else
        pslverr_d = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q <= `DWT_CTRL_RST;
      pready_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      pready_q <= pready_d;
      prdata_q <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

  // Pin sampled through two flops before status reads it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rdy_s1_q <= 1'b1;
      rdy_s2_q <= 1'b1;
    end
    else
    begin
      rdy_s1_q <= iochrdy_in;
      rdy_s2_q <= rdy_s1_q;
    end
  end

  // I/O wait counter, counted in bus clocks
  assign io_start = io_cycle & ~io_cycle_q;

  always_comb
  begin
    io_cnt_d = io_cnt_q;
    if (io_cnt_q != 3'h0)
      io_cnt_d = io_cnt_q - 3'h1;
    // load one to four waits; port 70h is skipped by the decode
    else if (io_start && core_port(io_port))
      io_cnt_d = {1'b0, ctrl_q[`DWT_IO_WS_HI:`DWT_IO_WS_LO]} + 3'h1;
  end

  // transfer clock enable: every cycle or every other cycle
  always_comb
  begin
    tick_d = ctrl_q[`DWT_CLK_FAST] ? 1'b1 : ~tick_q;
  end

  // IOCHRDY pulled low for I/O waits and DMA stretch
  always_comb
  begin
    oe_d = (io_cnt_d != 3'h0) | seq_stretch;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      io_cycle_q <= 1'b0;
      io_cnt_q <= 3'h0;
      tick_q <= 1'b0;
      oe_q <= 1'b0;
    end
    else
    begin
      io_cycle_q <= io_cycle;
      io_cnt_q <= io_cnt_d;
      tick_q <= tick_d;
      oe_q <= oe_d;
    end
  end

  dwt_dma_seq u_seq (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick_q),
    .start(dma_start),
    .wide(dma_wide),
    .mem_to_io(dma_mem_to_io),
    .memr_nodelay(ctrl_q[`DWT_MEMR_NODLY]),
    .ws16(ctrl_q[`DWT_WS16_HI:`DWT_WS16_LO]),
    .ws8(ctrl_q[`DWT_WS8_HI:`DWT_WS8_LO]),
    .hold(local_hold),
    .ior_n(ior_n),
    .iow_n(iow_n),
    .memr_n(memr_n),
    .memw_n(memw_n),
    .busy(seq_busy),
    .done(dma_done),
    .stretch(seq_stretch)
  );

  assign dma_busy = seq_busy;
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign iochrdy_out = 1'b0;
  assign iochrdy_oe = oe_q;

  property p_io_ws_min;
    @(posedge pclk) disable iff (!presetn)
    io_start && core_port(io_port) && io_cnt_q == 3'h0 && ctrl_q[7:6] == 2'b00
      |=> io_cnt_q == 3'h1 ##1 io_cnt_q == 3'h0;
  endproperty
  a_io_ws_min: assert property (p_io_ws_min) else $error("one I/O wait not given");

  property p_io_ws_max;
    @(posedge pclk) disable iff (!presetn)
    io_start && core_port(io_port) && io_cnt_q == 3'h0 && ctrl_q[7:6] == 2'b11
      |=> (io_cnt_q != 3'h0) [*4] ##1 io_cnt_q == 3'h0;
  endproperty
  a_io_ws_max: assert property (p_io_ws_max) else $error("four I/O waits not given");

  property p_port70;
    @(posedge pclk) disable iff (!presetn)
    io_start && io_port == `DWT_PORT_RTC && io_cnt_q == 3'h0 |=> io_cnt_q == 3'h0;
  endproperty
  a_port70: assert property (p_port70) else $error("port 70h received wait states");

  property p_reset_val;
    @(posedge pclk)
    $rose(presetn) |-> ctrl_q == 8'hC0;
  endproperty
  a_reset_val: assert property (p_reset_val) else $error("control register reset value wrong");

  property p_slow_tick;
    @(posedge pclk) disable iff (!presetn)
    !ctrl_q[0] && tick_q |=> !tick_q;
  endproperty
  a_slow_tick: assert property (p_slow_tick) else $error("slow transfer clock ticked twice");

  property p_fast_tick;
    @(posedge pclk) disable iff (!presetn)
    ctrl_q[0] |=> tick_q;
  endproperty
  a_fast_tick: assert property (p_fast_tick) else $error("fast transfer clock missed a cycle");

  property p_ctrl_write;
    @(posedge pclk) disable iff (!presetn)
    wr_ctrl |=> ctrl_q == $past(pwdata[7:0]);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("control write not stored");
endmodule // dwt_top
`default_nettype wire

// ---- bench/dwt_isa_model.sv ----
// Far-side bus model: counts strobe low cycles and IOCHRDY pulls.
// Assumes IOCHRDY has a pull-up; pull lets a peripheral hold it low.
`default_nettype none
module dwt_isa_model (
  input wire logic pclk,
  input wire logic clr,
  input wire logic pull,
  input wire logic ior_n,
  input wire logic iow_n,
  input wire logic memr_n,
  input wire logic memw_n,
  input wire logic iochrdy_out,
  input wire logic iochrdy_oe,
  output logic iochrdy_in,
  output logic [7:0] wr_low,
  output logic [7:0] rd_low,
  output logic [7:0] oe_len
);
  timeunit 1ns;
  timeprecision 1ps;
  // Wired line: any party pulling wins over the pull-up
  assign iochrdy_in = !(iochrdy_oe && !iochrdy_out) && !pull;
  always @(posedge pclk)
  begin
    if (clr)
    begin
      wr_low <= 8'h00;
      rd_low <= 8'h00;
      oe_len <= 8'h00;
    end
    else
    begin
      wr_low <= wr_low + 8'((!iow_n || !memw_n) ? 1 : 0);
      rd_low <= rd_low + 8'((!ior_n || !memr_n) ? 1 : 0);
      // Counts the line as the peripherals see it, so the driven level matters too
      oe_len <= oe_len + 8'(iochrdy_in ? 0 : 1);
    end
  end
endmodule // dwt_isa_model
`default_nettype wire

// ---- bench/dwt_top_test.sv ----
// Self-checking bench for the wait-state block over APB.
// Assumes the far-side model counts strobe cycles for each operation.
`default_nettype none
module dwt_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, io_cycle = 0, dma_start = 0, dma_wide = 0;
  logic dma_mem_to_io = 1, local_hold = 0, clr = 0, pull = 0;
  logic [7:0] io_port = 8'h00, wr_low, rd_low, oe_len;
  logic iochrdy_in, iochrdy_out, iochrdy_oe, ior_n, iow_n, memr_n, memw_n, dma_busy, dma_done;
  int bad_count = 0, num_checks = 0, cyc = 0, t, e;
  always #5 pclk = ~pclk;
  dwt_top dwt_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .io_cycle(io_cycle), .io_port(io_port), .dma_start(dma_start),
    .dma_wide(dma_wide), .dma_mem_to_io(dma_mem_to_io), .local_hold(local_hold),
    .iochrdy_in(iochrdy_in), .iochrdy_out(iochrdy_out), .iochrdy_oe(iochrdy_oe),
    .ior_n(ior_n), .iow_n(iow_n), .memr_n(memr_n), .memw_n(memw_n), .dma_busy(dma_busy),
    .dma_done(dma_done));
  dwt_isa_model dwt_isa_model_inst (.pclk(pclk), .clr(clr), .pull(pull), .ior_n(ior_n),
    .iow_n(iow_n), .memr_n(memr_n), .memw_n(memw_n), .iochrdy_out(iochrdy_out),
    .iochrdy_oe(iochrdy_oe), .iochrdy_in(iochrdy_in), .wr_low(wr_low), .rd_low(rd_low),
    .oe_len(oe_len));
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Holds the request until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task automatic clear_counts();
    clr <= 1;
    @(posedge pclk);
    clr <= 0;
  endtask
  task automatic io_access(input logic [7:0] port);
    clear_counts();
    io_port <= port;
    io_cycle <= 1;
    repeat (8) @(posedge pclk);
    io_cycle <= 0;
    repeat (2) @(posedge pclk);
  endtask
  task automatic dma(input logic wide);
    clear_counts();
    dma_wide <= wide;
    dma_start <= 1;
    @(posedge pclk);
    dma_start <= 0;
    @(posedge pclk);
    chk(dma_busy, 32'h1);
    do @(posedge pclk); while (dma_done !== 1'b1);
    repeat (2) @(posedge pclk);
    chk(dma_busy, 32'h0);
  endtask
  // Hang guard well above the expected run length
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      bad_count++;
      tally_and_finish();
    end
  end
  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    apb(0, 12'h004, 0);
    chk(rd, 32'hC0);
    apb(0, 12'h0FC, 0);
    chk(rd, 32'h0);
    chk(err, 32'h1);
    pull <= 1;
    repeat (4) @(posedge pclk);
    apb(0, 12'h008, 0);
    chk(rd, 32'h00); // line low
    pull <= 0;
    repeat (4) @(posedge pclk);
    apb(0, 12'h008, 0);
    chk(rd, 32'h20); // line released
    for (int c = 0; c < 4; c++)
    begin
      apb(1, 12'h004, 32'(c << 6));
      apb(0, 12'h004, 0);
      chk(rd, 32'(c << 6));
      io_access(8'h20);
      chk(oe_len, 8'(c + 1));
    end
    io_access(8'h70);
    chk(oe_len, 8'h00);
    for (int k = 0; k < 64; k++)
    begin
      t = (k & 1) ? 1 : 2;
      e = (k >> 4) + 2;
      dma_mem_to_io <= ((k & 4) == 0);
      if (k & 8)
        apb(1, 12'h004, 32'(((k >> 4) << 4) | ((3 - (k >> 4)) << 2) | (k & 3)));
      else
        apb(1, 12'h004, 32'(((3 - (k >> 4)) << 4) | ((k >> 4) << 2) | (k & 3)));
      dma((k & 8) != 0);
      chk(wr_low, 8'(e * t));
      chk(rd_low, 8'(e * t - ((k & 6) ? 0 : t)));
    end
    apb(1, 12'h004, 32'h01);
    local_hold <= 1;
    fork
      dma(0);
      begin
        repeat (12) @(posedge pclk);
        local_hold <= 0;
      end
    join
    chk(32'(oe_len != 0 && wr_low > 8'h02), 32'h1);
    tally_and_finish();
  end
endmodule // dwt_top_test
`default_nettype wire
